// >>> rtl/sba_defines.svh
// constants for the shared bus priority arbitration agent
// assumes inclusion by bare name from the package and the design files
`ifndef SBA_DEFINES_SVH
`define SBA_DEFINES_SVH

// number of agents on the cluster bus and width of an agent id
`define SBA_NUM_AGENTS   8
`define SBA_ID_W         3
// synchroniser depth for pin inputs
`define SBA_SYNC_STAGES  3
// idle (released) level of the active-low bus pins
`define SBA_PIN_IDLE     1'b1
// level driven onto an open-drain priority line while asserted
`define SBA_PIN_ACTIVE   1'b0
// agent id reset value of the rotation pointer: last agent, so agent 0 wins first
`define SBA_LAST_ID      3'h7
`define SBA_ID_ZERO      3'h0

`endif

// >>> rtl/sba_pkg.sv
// types for the shared bus priority arbitration agent
// assumes sba_defines.svh is on the include path
`include "sba_defines.svh"

package sba_pkg;

	// -------------------------------------------------------------
	// request classes, lowest to highest priority
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		SBA_CLS_NORMAL,
		SBA_CLS_DMA_HI,
		SBA_CLS_CORE
	} sba_class_t;

	// -------------------------------------------------------------
	// user side request and status bundles
	// -------------------------------------------------------------
	typedef struct packed {
		logic       valid;   // held high until the whole access is done
		sba_class_t cls;     // sampled when the request is first taken
	} sba_req_t;

	typedef struct packed {
		logic grant;         // this agent owns the bus and may run a transaction
		logic preempted;     // owner told to stop at the next transaction boundary
		logic waiting;       // request off: first cycle of each request, or held off or withdrawn for a higher class
	} sba_stat_t;

	// agent state machine
	typedef enum logic [2:0] {
		SBA_ST_IDLE,
		SBA_ST_REQ,
		SBA_ST_OWN,
		SBA_ST_YIELD,
		SBA_ST_BACKOFF
	} sba_state_t;

endpackage

// >>> rtl/sba_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin levels; output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module sba_sync #(
	parameter int          W        = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] level_q;
	logic [W-1:0] agree;

	// -------------------------------------------------------------
	// stage one is read only by stage two
	// -------------------------------------------------------------
	assign agree = ~(s2_q ^ s3_q);

	// shift chain and per-bit agreement update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q    <= RST_VAL;
			s2_q    <= RST_VAL;
			s3_q    <= RST_VAL;
			level_q <= RST_VAL;
		end else begin
			s1_q    <= pin_i;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= (agree & s3_q) | (~agree & level_q);
		end
	end

	assign level_o = level_q;

endmodule

`default_nettype wire

// >>> rtl/sba_agent.sv
// one bus agent of a shared cluster bus: request, priority lines and owner tracking
// assumes every agent sees all bus request lines and the two wired priority lines
//
// What this block does
// - a requester with core priority always beats one with dma priority.
// - a dma priority requester drops its request and dma line when another agent shows core.
// - a high priority dma agent holds its dma line with its request for the whole transfer.
// - a core access asserts the bus request together with the core priority line.
// - a pre-empted owner finishes the transaction in flight before dropping its lines.
// - after a core access the agent drops its request and core priority line.
// - a pre-empted dma agent re-requests with dma priority once core priority goes away.
// - a normal requester keeps its request off while another agent shows dma priority.
// - after a high priority dma transfer the agent drops its request and dma line.
// - equal class owners rotate upward by id after the last owner, skipping idle agents.
// - among simultaneous core requesters the next in id order wins first.
`timescale 1ns/1ps
`default_nettype none
`include "sba_defines.svh"

module sba_agent (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// strap, caught while reset is high
	input  wire logic [`SBA_ID_W-1:0]         agent_id_i,
	// bus pins, active low except bus_owner_indicator_o, which is active high
	input  wire logic [`SBA_NUM_AGENTS-1:0]   bus_request_line_n_i,
	output logic                              bus_request_line_n_o,
	input  wire logic                         core_priority_request_n_i,
	output logic                              core_priority_request_n_o,
	output logic                              core_priority_request_oe_n_o,
	input  wire logic                         dma_priority_request_n_i,
	output logic                              dma_priority_request_n_o,
	output logic                              dma_priority_request_oe_n_o,
	output logic                              bus_owner_indicator_o,
	// user side
	input  wire sba_pkg::sba_req_t            req_i,
	input  wire logic                         xact_end_i,
	input  wire logic                         done_i,
	output sba_pkg::sba_stat_t                stat_o
);

	localparam int N = `SBA_NUM_AGENTS;
	localparam int SW = `SBA_NUM_AGENTS + 2;

	logic [`SBA_ID_W-1:0]  id_q;
	logic [SW-1:0]         pins_n;
	logic [N-1:0]          br_s;
	logic                  cpa_s;
	logic                  dpa_s;
	logic                  owner_vld_q;
	logic [`SBA_ID_W-1:0]  owner_q;
	logic                  owner_keep;
	logic                  any_req;
	logic [`SBA_ID_W-1:0]  winner;
	logic                  owner_vld_d;
	logic [`SBA_ID_W-1:0]  owner_d;
	logic                  own_q;
	sba_pkg::sba_state_t   state_q;
	sba_pkg::sba_state_t   state_d;
	sba_pkg::sba_class_t   cls_q;
	sba_pkg::sba_class_t   cls_d;
	logic                  blocked;
	logic                  drive_br;
	logic                  drive_cpa;
	logic                  drive_dpa;
	logic                  br_q;
	logic                  cpa_q;
	logic                  dpa_q;

	// -------------------------------------------------------------
	// pin sampling
	// -------------------------------------------------------------

	// all lines, own request included, go through the same filter so
	// every agent computes ownership from identical samples
	sba_sync #(
		.W       (SW),
		.RST_VAL ({SW{`SBA_PIN_IDLE}})
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.pin_i   ({dma_priority_request_n_i, core_priority_request_n_i, bus_request_line_n_i}),
		.level_o (pins_n)
	);

	assign br_s  = ~pins_n[N-1:0];
	assign cpa_s = ~pins_n[N];
	assign dpa_s = ~pins_n[N+1];

	// id strap is taken each cycle of reset and frozen afterwards
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			id_q <= agent_id_i;
		end
	end

	// -------------------------------------------------------------
	// owner tracking
	// -------------------------------------------------------------

	// next requester strictly after the last owner, wrapping around
	function automatic logic [`SBA_ID_W-1:0] rot_pick(
		input logic [N-1:0]         req,
		input logic [`SBA_ID_W-1:0] last
	);
		logic [`SBA_ID_W-1:0] idx;
		logic                 found;
		rot_pick = last;
		found    = 1'b0;
		idx      = last;
		for (int i = 0; i < N; i++) begin
			idx = idx + `SBA_ID_W'(1);
			if (!found && req[idx]) begin
				rot_pick = idx;
				found    = 1'b1;
			end
		end
	endfunction

	// owner holds the bus while its request stays low; lower classes have
	// already withdrawn, so rotation over live requests settles priority
	assign owner_keep  = owner_vld_q && br_s[owner_q];
	assign any_req     = |br_s;
	assign winner      = rot_pick(br_s, owner_q);
	assign owner_vld_d = owner_keep || any_req;
	assign owner_d     = (!owner_keep && any_req) ? winner : owner_q;

	// owner pointer survives an idle bus so rotation resumes after it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			owner_vld_q <= 1'b0;
			owner_q     <= `SBA_LAST_ID;
			own_q       <= 1'b0;
		end else begin
			owner_vld_q <= owner_vld_d;
			owner_q     <= owner_d;
			own_q       <= owner_vld_d && (owner_d == id_q);
		end
	end

	// -------------------------------------------------------------
	// agent state machine
	// -------------------------------------------------------------

	// a higher class shown by another agent; a core agent is never blocked.
	// a normal agent never drives the dma line, so its own echo cannot block it
	always_comb begin
		case (cls_q)
			sba_pkg::SBA_CLS_CORE:   blocked = 1'b0;
			sba_pkg::SBA_CLS_DMA_HI: blocked = cpa_s;
			sba_pkg::SBA_CLS_NORMAL: blocked = cpa_s || dpa_s;
			default:                 blocked = 1'b0;
		endcase
	end

	// next state and class capture
	always_comb begin
		state_d = state_q;
		cls_d   = cls_q;
		case (state_q)
			sba_pkg::SBA_ST_IDLE: begin
				if (req_i.valid) begin
					cls_d   = req_i.cls;
					state_d = sba_pkg::SBA_ST_BACKOFF;
				end
			end
			sba_pkg::SBA_ST_REQ: begin
				if (blocked) begin
					state_d = sba_pkg::SBA_ST_BACKOFF;
				end else if (own_q) begin
					state_d = sba_pkg::SBA_ST_OWN;
				end
			end
			sba_pkg::SBA_ST_OWN: begin
				if (done_i) begin
					state_d = sba_pkg::SBA_ST_IDLE;
				end else if (blocked && xact_end_i) begin
					state_d = sba_pkg::SBA_ST_BACKOFF;
				end else if (blocked) begin
					state_d = sba_pkg::SBA_ST_YIELD;
				end
			end
			sba_pkg::SBA_ST_YIELD: begin
				// lines stay up until the transaction in flight is over
				if (done_i) begin
					state_d = sba_pkg::SBA_ST_IDLE;
				end else if (xact_end_i) begin
					state_d = sba_pkg::SBA_ST_BACKOFF;
				end
			end
			sba_pkg::SBA_ST_BACKOFF: begin
				if (!blocked) begin
					state_d = sba_pkg::SBA_ST_REQ;
				end
			end
			default: state_d = sba_pkg::SBA_ST_IDLE;
		endcase
	end

	// request and priority lines follow the next state so pins come from flops
	assign drive_br  = (state_d == sba_pkg::SBA_ST_REQ) ||
			   (state_d == sba_pkg::SBA_ST_OWN) ||
			   (state_d == sba_pkg::SBA_ST_YIELD);
	assign drive_cpa = drive_br && (cls_d == sba_pkg::SBA_CLS_CORE);
	assign drive_dpa = drive_br && (cls_d == sba_pkg::SBA_CLS_DMA_HI);

	// state, class and pin drive registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= sba_pkg::SBA_ST_IDLE;
			cls_q   <= sba_pkg::SBA_CLS_NORMAL;
			br_q    <= 1'b0;
			cpa_q   <= 1'b0;
			dpa_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cls_q   <= cls_d;
			br_q    <= drive_br;
			cpa_q   <= drive_cpa;
			dpa_q   <= drive_dpa;
		end
	end

	// -------------------------------------------------------------
	// pin and status outputs
	// -------------------------------------------------------------

	// priority lines are wired: drive low only while asserting, else release
	assign bus_request_line_n_o         = ~br_q;
	assign core_priority_request_n_o    = `SBA_PIN_ACTIVE;
	assign core_priority_request_oe_n_o = ~cpa_q;
	assign dma_priority_request_n_o     = `SBA_PIN_ACTIVE;
	assign dma_priority_request_oe_n_o  = ~dpa_q;
	assign bus_owner_indicator_o        = own_q;

	// grant only while owning and not yet told to yield; one driver for the whole bundle
	assign stat_o = '{
		grant:     (state_q == sba_pkg::SBA_ST_OWN) && own_q,
		preempted: (state_q == sba_pkg::SBA_ST_YIELD),
		waiting:   (state_q == sba_pkg::SBA_ST_BACKOFF)
	};

endmodule

`default_nettype wire

// >>> sim/sba_agent_properties.sv
// concurrent checks on one bus agent's pins and status
// assumes bound to sba_agent; single clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none

module sba_agent_properties (
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic               bus_request_line_n_o,
	input wire logic               core_priority_request_n_i,
	input wire logic               core_priority_request_oe_n_o,
	input wire logic               dma_priority_request_n_i,
	input wire logic               dma_priority_request_oe_n_o,
	input wire logic               bus_owner_indicator_o,
	input wire logic               xact_end_i,
	input wire logic               done_i,
	input wire sba_pkg::sba_stat_t stat_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// -------------------------------------------------------------
	// pairing, withdrawal and hand-over
	// -------------------------------------------------------------
	// repeat counts leave room for the four-flop pin filter
	AST_CORE_PAIR: assert property (!core_priority_request_oe_n_o |-> !bus_request_line_n_o)
		else $error("core line driven without request");
	AST_DMA_PAIR: assert property (!dma_priority_request_oe_n_o |-> !bus_request_line_n_o)
		else $error("dma line driven without request");
	AST_ONE_CLASS: assert property (!(!core_priority_request_oe_n_o && !dma_priority_request_oe_n_o))
		else $error("both priority lines driven");
	AST_DMA_WITHDRAW: assert property ((!core_priority_request_n_i && core_priority_request_oe_n_o
		&& !stat_o.preempted) [*7] |-> dma_priority_request_oe_n_o && bus_request_line_n_o)
		else $error("request kept against foreign core line");
	AST_NORMAL_YIELD: assert property ((!dma_priority_request_n_i && dma_priority_request_oe_n_o
		&& core_priority_request_oe_n_o && !stat_o.preempted) [*7] |-> bus_request_line_n_o)
		else $error("normal request kept against dma line");
	AST_PREEMPT_HOLD: assert property (stat_o.preempted && !xact_end_i && !done_i |=> !bus_request_line_n_o)
		else $error("request dropped inside a transaction");
	AST_PREEMPT_FREE: assert property (stat_o.preempted && xact_end_i && !done_i |=>
		bus_request_line_n_o && core_priority_request_oe_n_o && dma_priority_request_oe_n_o)
		else $error("lines kept after transaction end");
	AST_DONE_FREE: assert property (stat_o.grant && done_i |=> bus_request_line_n_o
		&& core_priority_request_oe_n_o && dma_priority_request_oe_n_o)
		else $error("lines kept after access done");
	AST_RETRY: assert property ($rose(core_priority_request_n_i) && stat_o.waiting
		&& dma_priority_request_n_i |-> ##[1:12] !bus_request_line_n_o)
		else $error("no re-request after core line released");
	AST_GRANT_OWNER: assert property (stat_o.grant |-> !bus_request_line_n_o)
		else $error("grant while own request line released");
endmodule

bind sba_agent sba_agent_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
	.bus_request_line_n_o(bus_request_line_n_o), .core_priority_request_n_i(core_priority_request_n_i),
	.core_priority_request_oe_n_o(core_priority_request_oe_n_o),
	.dma_priority_request_n_i(dma_priority_request_n_i),
	.dma_priority_request_oe_n_o(dma_priority_request_oe_n_o),
	.bus_owner_indicator_o(bus_owner_indicator_o), .xact_end_i(xact_end_i), .done_i(done_i),
	.stat_o(stat_o));

`default_nettype wire

// >>> sim/sba_peers.sv
// the seven other agents of the cluster bus and the pulled-up wired lines
// assumes the bench says which peers want the bus and with what class
`timescale 1ns/1ps
`default_nettype none

module sba_peers (
	input  wire logic       want_i [7:0],
	input  wire logic       core_i,
	input  wire logic       dma_i,
	input  wire logic       own_req_n_i,
	input  wire logic       core_oe_n_i,
	input  wire logic       dma_oe_n_i,
	output logic      [7:0] req_n_o,
	output logic            core_n_o,
	output logic            dma_n_o
);
	wire logic any_w = |{want_i[7], want_i[6], want_i[5], want_i[4], want_i[3], want_i[2], want_i[1]};
	// -------------------------------------------------------------
	// pin levels; a peer drives a priority line only with its request
	// -------------------------------------------------------------
	assign req_n_o  = {~want_i[7], ~want_i[6], ~want_i[5], ~want_i[4],
		~want_i[3], ~want_i[2], ~want_i[1], own_req_n_i};
	assign core_n_o = !((core_i && any_w) || !core_oe_n_i);
	assign dma_n_o  = !((dma_i && any_w) || !dma_oe_n_i);
endmodule

`default_nettype wire

// >>> sim/sba_agent_tb.sv
// self-checking bench for one bus agent with id 0 among seven peers
// assumes sba_pkg, sba_sync and sba_agent are compiled first
`timescale 1ns/1ps
`default_nettype none

module sba_agent_tb;
	logic               clk_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               want [7:0] = '{default: 1'b0};
	logic               pc = 1'b0, pd = 1'b0, xe = 1'b0, dn = 1'b0;
	logic               rn, coe, doe, own, cn, dl, cdv, ddv;
	logic         [7:0] rq_n, m;
	sba_pkg::sba_req_t  req = '0;
	sba_pkg::sba_stat_t st;
	int                 err_total = 0, n_checks = 0, cyc = 0, last, nx, r;
	int                 order [$];
	always #10 clk_i = ~clk_i;
	sba_peers u_sba_peers (.want_i(want), .core_i(pc), .dma_i(pd), .own_req_n_i(rn),
		.core_oe_n_i(coe), .dma_oe_n_i(doe), .req_n_o(rq_n), .core_n_o(cn), .dma_n_o(dl));
	sba_agent u_sba_agent (.clk_i(clk_i), .rst_i(rst_i), .agent_id_i(3'h0),
		.bus_request_line_n_i(rq_n), .bus_request_line_n_o(rn), .core_priority_request_n_i(cn),
		.core_priority_request_n_o(cdv), .core_priority_request_oe_n_o(coe),
		.dma_priority_request_n_i(dl), .dma_priority_request_n_o(ddv), .dma_priority_request_oe_n_o(doe),
		.bus_owner_indicator_o(own), .req_i(req), .xact_end_i(xe), .done_i(dn), .stat_o(st));
	// -------------------------------------------------------------
	// model, compare and control tasks
	// -------------------------------------------------------------
	// rotation model: next requester after the last owner, ascending with wrap
	function automatic int next_own(input int lst, input logic [7:0] msk);
		for (int k = 1; k <= 8; k++) begin
			if (msk[(lst + k) % 8]) return (lst + k) % 8;
		end
		return -1;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// bounded wait on one status bit: 2 grant, 1 preempted, 0 waiting
	task automatic wait_st(input int b);
		for (int i = 0; i < 80 && st[b] !== 1'b1; i++) begin
			@(posedge clk_i);
			#1;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic ask(input sba_pkg::sba_class_t c);
		@(posedge clk_i) req <= '{1'b1, c};
	endtask
	// done ends the access, so valid falls with it
	task automatic finish_acc();
		@(posedge clk_i) begin dn <= 1'b1; req.valid <= 1'b0; end
		@(posedge clk_i) dn <= 1'b0;
		tick(2);
	endtask
	// hang guard: whole run is a few hundred cycles, plus every bounded wait running out
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			stop_test();
		end
	end
	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		void'($urandom(32'h7ae8));
		tick(7);
		@(posedge clk_i) rst_i <= 1'b0;
		tick(1);
		check({rn, coe, doe, own, st}, 8'h70);
		// core request together with peer 4 core request, pointer at 7
		ask(sba_pkg::SBA_CLS_CORE);
		// own line falls two edges after valid, so peer 4 joins on that same edge
		@(posedge clk_i);
		@(posedge clk_i) begin want[4] <= 1'b1; pc <= 1'b1; end
		wait_st(2);
		check(st.grant, next_own(7, 8'h11) == 0);
		check({rn, coe, doe}, 8'h01);
		check({cdv, ddv}, 8'h00);
		finish_acc();
		check({rn, coe, doe}, 8'h07);
		@(posedge clk_i) begin want[4] <= 1'b0; pc <= 1'b0; end
		$display("test core access done");
		// dma transfer pre-empted by a peer core access, then resumed
		tick(8);
		ask(sba_pkg::SBA_CLS_DMA_HI);
		wait_st(2);
		check({st.grant, rn, doe}, 8'h04);
		@(posedge clk_i) begin want[1] <= 1'b1; pc <= 1'b1; end
		wait_st(1);
		tick(3);
		check({st.preempted, rn, doe}, 8'h04);
		@(posedge clk_i) xe <= 1'b1;
		@(posedge clk_i) xe <= 1'b0;
		tick(2);
		check({rn, coe, doe, st.waiting}, 8'h0F);
		@(posedge clk_i) begin want[1] <= 1'b0; pc <= 1'b0; end
		wait_st(2);
		check({st.grant, rn, doe}, 8'h04);
		finish_acc();
		check({rn, coe, doe}, 8'h07);
		$display("test dma pre-emption done");
		// normal request while peer 3 holds dma priority
		@(posedge clk_i) begin want[3] <= 1'b1; pd <= 1'b1; end
		tick(6);
		ask(sba_pkg::SBA_CLS_NORMAL);
		tick(10);
		check({rn, st.waiting}, 8'h03);
		@(posedge clk_i) begin want[3] <= 1'b0; pd <= 1'b0; end
		wait_st(2);
		check(st.grant, 8'h01);
		finish_acc();
		$display("test dma blocking done");
		// rotation with a random set of peers; this agent owned last
		for (r = 0; r < 2; r++) begin
			last = 0;
			m = 8'($urandom_range(1, 127)) << 1;
			order.delete();
			nx = next_own(last, m | 8'h01);
			while (nx != 0) begin
				order.push_back(nx);
				nx = next_own(nx, m);
				if (nx < 0 || nx <= order[$]) nx = 0;
			end
			@(posedge clk_i) for (int k = 1; k < 8; k++) want[k] <= m[k];
			ask(sba_pkg::SBA_CLS_NORMAL);
			foreach (order[i]) begin
				tick(10);
				check({own, st.grant}, 8'h00);
				@(posedge clk_i) want[order[i]] <= 1'b0;
			end
			wait_st(2);
			check({own, st.grant}, 8'h03);
			finish_acc();
			tick(6);
		end
		$display("test rotation done");
		stop_test();
	end
endmodule

`default_nettype wire
